// >>> design/spims_baud.sv
// Free-running bit-rate timer: one tick per serial half period.
// Assumes the core holds run high while it is an enabled master.
module spims_baud #(
  parameter int CW = 8
) (
  input  wire logic      sys_clk_i,
  input  wire logic      rst_n_i,
  spims_baud_if.timer    bif
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] reload;
  logic          tick_q;
  logic          tick_d;

  always_comb begin
    // Half period is divider/2, so 4..512 maps to 2..256 cycles
    reload = CW'((32'd2 << bif.rate) - 32'd1);
    tick_d = 1'b0;
    cnt_d  = cnt_q - CW'(1);
    if (!bif.run) begin
      cnt_d = reload;
    end else if (cnt_q == '0) begin
      cnt_d  = reload;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign bif.tick = tick_q;

  a_tick_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tick_q && bif.run && bif.rate == 3'h0 && $past(bif.run) |=> !tick_q ##1 (tick_q || !bif.run || bif.rate != 3'h0))
    else $error("tick spacing wrong for fastest rate");
endmodule // spims_baud

// >>> design/spims_core.sv
// SPI master/slave port with byte registers on a plain register port.
// Assumes pin inputs are asynchronous; pads resolve the enables outside.
// Functional notes
// - Eight shifts exchange one character full duplex
// - Single transmit buffer, separate receive buffer
// - Master sees low select input as fault
// - Mode fault turns off output drivers
// - Slave shifts only while select input low
// - Master makes eight clocks, drives clock enable
// - Slave uses slave lines, master uses master lines
// - Data write during transfer flags collision
// - Control bit seven enables interrupt request
// - Control bit six switches port on
// - Control bit four selects master mode
// - Control bit three sets clock idle level
// - Phase bit resets one, others zero
// - Rate field divides clock by 4..512
// - Mask bits drive select outputs, reset ones
// - Mask applied when master transfer starts
// - Data write starts, shifting on timer overflow
// - Most significant bit goes first
// - Fault clears mode and enable, sets flag
// - Flags clear by status read then access
`include "spims_map.svh"
module spims_core (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       ss_n_i,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            clock_driver_enable_o,
  input  wire logic       slave_in_i,
  output logic            slave_out_o,
  output logic            slave_out_driver_enable_o,
  input  wire logic       master_serial_in_i,
  output logic            master_serial_out_o,
  output logic            master_out_en_o,
  output logic      [7:0] select_out_pins_n_o,
  output logic            irq_o
);
  spims_pkg::spims_state_t st_q;
  spims_pkg::spims_state_t st_d;
  logic [7:0] ctrl_q, ctrl_d, mask_q, mask_d, shreg_q, shreg_d;
  logic [7:0] rx_q, rx_d, ssel_q, ssel_d, rdata_d, sh_n;
  logic [3:0] half_q, half_d, cnt_q, cnt_d;
  logic       autosel_q, autosel_d, done_q, done_d, write_collision_flag_q, write_collision_flag_d, mode_fault_flag_q, mode_fault_flag_d;
  logic       arm_f_q, arm_f_d, arm_m_q, arm_m_d, sck_q, sck_d, out_q, out_d, sck_p_q;
  logic       irq_q, irq_d, cken_q, cken_d, moen_q, moen_d, slave_out_driver_enable_q, slave_out_driver_enable_d;
  logic       pend_q, pend_d, fin_q, fin_d;
  logic       wr_ctrl, wr_flags, wr_data, wr_mask, rd_flags, rd_data;
  logic       master, core_en, clock_phase_bit, clock_polarity_bit, busy, fault, start;
  logic       edge_v, lead, sample, din, done_m, done_s;
  logic [3:0] syn;
  logic       ss_s, sck_s, si_s, mi_s;

  spims_baud_if bif ();

  // Select idles high so reset never looks like a foreign master
  spims_sync #(
    .W    (4),
    .INIT (4'h8)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({ss_n_i, sck_i, slave_in_i, master_serial_in_i}),
    .q_o       (syn)
  );

  spims_baud #(
    .CW (8)
  ) u_baud (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .bif       (bif.timer)
  );

  assign ss_s     = syn[3];
  assign sck_s    = syn[2];
  assign si_s     = syn[1];
  assign mi_s     = syn[0];
  assign master   = ctrl_q[`SPIMS_B_MASTER];
  assign core_en  = ctrl_q[`SPIMS_B_CORE_EN];
  assign clock_phase_bit     = ctrl_q[`SPIMS_B_CLOCK_PHASE_BIT];
  assign clock_polarity_bit     = ctrl_q[`SPIMS_B_CLOCK_POLARITY_BIT];
  assign bif.run  = core_en && master;
  assign bif.rate = {ctrl_q[`SPIMS_B_RATE2], ctrl_q[1:0]};
  assign wr_ctrl  = wr_i && addr_i == `SPIMS_ADDR_CTRL;
  assign wr_flags = wr_i && addr_i == `SPIMS_ADDR_FLAGS;
  assign wr_data  = wr_i && addr_i == `SPIMS_ADDR_DATA;
  assign wr_mask  = wr_i && addr_i == `SPIMS_ADDR_MASK;
  assign rd_flags = rd_i && addr_i == `SPIMS_ADDR_FLAGS;
  assign rd_data  = rd_i && addr_i == `SPIMS_ADDR_DATA;
  // With phase 0 a slave cannot tell where a byte begins, so a low select counts as busy
  assign busy     = master ? (st_q != spims_pkg::st_idle) : (!ss_s && (!clock_phase_bit || cnt_q != 4'h0));
  assign fault    = core_en && master && !ss_s;
  assign start    = core_en && master && ss_s && st_q == spims_pkg::st_idle && wr_data;

  always_comb begin
    st_d      = st_q;
    ctrl_d    = ctrl_q;
    mask_d    = mask_q;
    shreg_d   = shreg_q;
    rx_d      = rx_q;
    ssel_d    = ssel_q;
    half_d    = half_q;
    cnt_d     = cnt_q;
    autosel_d = autosel_q;
    done_d    = done_q;
    write_collision_flag_d    = write_collision_flag_q;
    mode_fault_flag_d    = mode_fault_flag_q;
    arm_f_d   = arm_f_q;
    arm_m_d   = arm_m_q;
    sck_d     = sck_q;
    out_d     = out_q;
    pend_d    = 1'b0;
    fin_d     = 1'b0;
    sh_n      = shreg_q;
    edge_v    = 1'b0;
    lead      = 1'b0;
    din       = 1'b0;
    done_m    = 1'b0;
    done_s    = 1'b0;
    if (wr_ctrl) begin
      ctrl_d = wdata_i;
    end
    if (wr_mask) begin
      mask_d = wdata_i;
    end
    if (wr_flags) begin
      autosel_d = wdata_i[`SPIMS_B_AUTOSEL];
    end
    // Clear sequences: arm on status read, fire on the following access
    if (rd_flags && (done_q || write_collision_flag_q)) begin
      arm_f_d = 1'b1;
    end
    if (rd_flags && mode_fault_flag_q) begin
      arm_m_d = 1'b1;
    end
    if ((wr_data || rd_data) && arm_f_q) begin
      done_d  = 1'b0;
      write_collision_flag_d  = 1'b0;
      arm_f_d = 1'b0;
    end
    if (wr_ctrl && arm_m_q) begin
      mode_fault_flag_d  = 1'b0;
      arm_m_d = 1'b0;
    end
    // A colliding write is dropped; the running byte continues untouched
    if (wr_data && busy && core_en) begin
      write_collision_flag_d = 1'b1;
    end else if (wr_data) begin
      shreg_d = wdata_i;
    end
    if (core_en && master) begin
      if (fault) begin
        ctrl_d[`SPIMS_B_MASTER]  = 1'b0;
        ctrl_d[`SPIMS_B_CORE_EN] = 1'b0;
        mode_fault_flag_d = 1'b1;
        st_d   = spims_pkg::st_idle;
        sck_d  = clock_polarity_bit;
        ssel_d = `SPIMS_MASK_RST;
      end else begin
        case (st_q)
          spims_pkg::st_idle: begin
            sck_d = clock_polarity_bit;
            if (start) begin
              st_d   = spims_pkg::st_wait;
              half_d = 4'h0;
              if (!clock_phase_bit) begin
                out_d = wdata_i[7];
              end
              if (autosel_q) begin
                ssel_d = mask_q;
              end
            end
          end
          spims_pkg::st_wait: begin
            if (bif.tick) begin
              st_d = spims_pkg::st_shift;
            end
          end
          spims_pkg::st_shift: begin
            if (pend_q && fin_q) begin
              st_d   = spims_pkg::st_idle;
              done_m = 1'b1;
            end else if (bif.tick) begin
              sck_d  = ~sck_q;
              edge_v = 1'b1;
              lead   = !half_q[0];
              half_d = half_q + 4'h1;
              // Input crosses two sync flops, so its sample trails the clock edge by a cycle
              pend_d = lead ^ clock_phase_bit;
              fin_d  = half_q == `SPIMS_HALF_BITS;
              if (half_q == `SPIMS_HALF_BITS && !pend_d) begin
                st_d   = spims_pkg::st_idle;
                done_m = 1'b1;
              end
            end
          end
          default: begin
            st_d = spims_pkg::st_idle;
          end
        endcase
      end
    end else begin
      st_d   = spims_pkg::st_idle;
      half_d = 4'h0;
      sck_d  = clock_polarity_bit;
      if (core_en) begin
        if (ss_s) begin
          cnt_d = 4'h0;
          out_d = shreg_d[7];
        end else if (sck_s != sck_p_q) begin
          edge_v = 1'b1;
          lead   = sck_s != clock_polarity_bit;
          din    = si_s;
        end
      end
    end
    if (pend_q && master) begin
      din = mi_s;
    end
    sample = (edge_v && !master && (lead ^ clock_phase_bit)) || (pend_q && master);
    if (sample) begin
      sh_n    = {shreg_q[6:0], din};
      shreg_d = sh_n;
      if (!master) begin
        cnt_d  = cnt_q + 4'h1;
        done_s = cnt_q == (`SPIMS_CHAR_BITS - 4'h1);
      end
    end
    if (edge_v && !(lead ^ clock_phase_bit)) begin
      out_d = shreg_q[7];
    end
    if (done_m || done_s) begin
      done_d = 1'b1;
      rx_d   = sh_n;
      cnt_d  = 4'h0;
      if (done_m && autosel_q) begin
        ssel_d = `SPIMS_MASK_RST;
      end
    end
    if (!autosel_d) begin
      ssel_d = mask_d;
    end else if (!autosel_q) begin
      ssel_d = `SPIMS_MASK_RST;
    end
    rdata_d = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `SPIMS_ADDR_CTRL:  rdata_d = ctrl_q;
        `SPIMS_ADDR_FLAGS: rdata_d = {done_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 3'h0, autosel_q};
        `SPIMS_ADDR_DATA:  rdata_d = rx_q;
        `SPIMS_ADDR_MASK:  rdata_d = mask_q;
        default:           rdata_d = 8'h00;
      endcase
    end
    irq_d  = ctrl_d[`SPIMS_B_IRQEN] && (done_d || write_collision_flag_d || mode_fault_flag_d);
    cken_d = ctrl_d[`SPIMS_B_CORE_EN] && ctrl_d[`SPIMS_B_MASTER];
    moen_d = cken_d;
    slave_out_driver_enable_d = ctrl_d[`SPIMS_B_CORE_EN] && !ctrl_d[`SPIMS_B_MASTER] && !ss_s;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q      <= spims_pkg::st_idle;
      ctrl_q    <= `SPIMS_CTRL_RST;
      mask_q    <= `SPIMS_MASK_RST;
      ssel_q    <= `SPIMS_MASK_RST;
      shreg_q   <= 8'h00;
      rx_q      <= 8'h00;
      rdata_o   <= 8'h00;
      half_q    <= 4'h0;
      cnt_q     <= 4'h0;
      autosel_q <= `SPIMS_AUTOSEL_RST;
      done_q    <= 1'b0;
      write_collision_flag_q    <= 1'b0;
      mode_fault_flag_q    <= 1'b0;
      arm_f_q   <= 1'b0;
      arm_m_q   <= 1'b0;
      sck_q     <= 1'b0;
      sck_p_q   <= 1'b0;
      out_q     <= 1'b0;
      irq_q     <= 1'b0;
      cken_q    <= 1'b0;
      moen_q    <= 1'b0;
      slave_out_driver_enable_q    <= 1'b0;
      pend_q    <= 1'b0;
      fin_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      ctrl_q    <= ctrl_d;
      mask_q    <= mask_d;
      ssel_q    <= ssel_d;
      shreg_q   <= shreg_d;
      rx_q      <= rx_d;
      rdata_o   <= rdata_d;
      half_q    <= half_d;
      cnt_q     <= cnt_d;
      autosel_q <= autosel_d;
      done_q    <= done_d;
      write_collision_flag_q    <= write_collision_flag_d;
      mode_fault_flag_q    <= mode_fault_flag_d;
      arm_f_q   <= arm_f_d;
      arm_m_q   <= arm_m_d;
      sck_q     <= sck_d;
      sck_p_q   <= sck_s;
      out_q     <= out_d;
      irq_q     <= irq_d;
      cken_q    <= cken_d;
      moen_q    <= moen_d;
      slave_out_driver_enable_q    <= slave_out_driver_enable_d;
      pend_q    <= pend_d;
      fin_q     <= fin_d;
    end
  end

  assign sck_o                     = sck_q;
  assign clock_driver_enable_o     = cken_q;
  assign master_out_en_o           = moen_q;
  assign slave_out_driver_enable_o = slave_out_driver_enable_q;
  assign master_serial_out_o       = out_q;
  assign slave_out_o               = out_q;
  assign select_out_pins_n_o       = ssel_q;
  assign irq_o                     = irq_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_mode_fault_set: assert property (fault |=> !ctrl_q[6] && !ctrl_q[4] && mode_fault_flag_q)
    else $error("mode fault did not drop mode and enable");
  a_fault_drivers_off: assert property (fault |=> !clock_driver_enable_o && !master_out_en_o)
    else $error("drivers still on after mode fault");
  a_collision_flag: assert property (wr_data && busy && core_en |=> write_collision_flag_q)
    else $error("collision not flagged");
  a_shifter_kept: assert property (wr_data && busy && core_en && !sample |=> shreg_q == $past(shreg_q))
    else $error("colliding write reached shifter");
  a_slave_ignore_clk: assert property (!master && ss_s |=> cnt_q == 4'h0)
    else $error("slave counted with select high");
  a_eight_clocks: assert property (st_q == spims_pkg::st_shift && bif.tick && half_q == 4'hf && !fault
    |=> sck_o == ctrl_q[3] ##[0:1] (st_q == spims_pkg::st_idle && done_q))
    else $error("master transfer end wrong");
  a_msb_first: assert property (start && !clock_phase_bit |=> master_serial_out_o == $past(wdata_i[7]))
    else $error("first bit is not msb");
  a_select_apply: assert property (start && autosel_q |=> select_out_pins_n_o == $past(mask_q))
    else $error("mask not applied at start");
  a_irq_gate_off: assert property (!ctrl_q[7] |-> !irq_o)
    else $error("interrupt while disabled");
  a_irq_raise: assert property (ctrl_q[7] && (done_q || write_collision_flag_q || mode_fault_flag_q) |-> irq_o)
    else $error("interrupt missing");
  a_flag_clear_seq: assert property (arm_f_q && rd_data && !done_m && !done_s |=> !done_q && !write_collision_flag_q)
    else $error("flags not cleared by sequence");
  a_ctrl_reset_val: assert property (@(posedge sys_clk_i) disable iff (1'b0)
    !rst_n_i |=> ctrl_q == 8'h04 && mask_q == 8'hff)
    else $error("reset values wrong");

  c_master_done: cover property (done_m);
  c_slave_done: cover property (done_s);
  c_mode_fault: cover property (fault);
  c_collision: cover property (wr_data && busy && core_en);
endmodule // spims_core

// >>> design/spims_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous single-bit levels.
module spims_sync #(
  parameter int           W    = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule // spims_sync

// >>> shared/spims_baud_if.sv
// Link between the SPI core and its bit-rate timer.
// Assumes both ends run on the same system clock.
interface spims_baud_if;
  logic                 run;
  spims_pkg::spims_rate_t rate;
  logic                 tick;
  modport timer (input run, input rate, output tick);
  modport core  (output run, output rate, input tick);
endinterface

// >>> shared/spims_map.svh
// Register map, field positions and reset values of the SPI port.
// Assumes byte-wide registers at the printed addresses on a plain port.
`ifndef SPIMS_MAP_SVH
`define SPIMS_MAP_SVH
`define SPIMS_ADDR_CTRL  8'hec
`define SPIMS_ADDR_FLAGS 8'hed
`define SPIMS_ADDR_DATA  8'hee
`define SPIMS_ADDR_MASK  8'hef
`define SPIMS_B_IRQEN    7
`define SPIMS_B_CORE_EN  6
`define SPIMS_B_RATE2    5
`define SPIMS_B_MASTER   4
`define SPIMS_B_CLOCK_POLARITY_BIT     3
`define SPIMS_B_CLOCK_PHASE_BIT     2
`define SPIMS_B_DONE     7
`define SPIMS_B_WRITE_COLLISION_FLAG     6
`define SPIMS_B_MODE_FAULT_FLAG     4
`define SPIMS_B_AUTOSEL  0
`define SPIMS_CTRL_RST   8'h04
`define SPIMS_MASK_RST   8'hff
`define SPIMS_FLAGS_RST  8'h00
`define SPIMS_AUTOSEL_RST 1'b0
`define SPIMS_HALF_BITS  4'hf
`define SPIMS_CHAR_BITS  4'h8
`endif

// >>> shared/spims_pkg.sv
// Types shared by the SPI port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package spims_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_wait  = 3'b010,
    st_shift = 3'b100
  } spims_state_t;
  typedef logic [2:0] spims_rate_t;
endpackage

// >>> tb/spi_master_slave_port_tb_top.sv
// Self-checking bench: register port tasks drive the core, a slave model answers.
// Assumes the register map header and a 50 MHz system clock.
`include "spims_map.svh"
module spi_master_slave_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SI = 8'h3c;
  logic       sys_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       ss_n_i    = 1'b1;
  logic       sck_i     = 1'b0;
  logic       slave_in_i = 1'b0;
  logic [7:0] m_tx      = 8'h00;
  logic [7:0] v;
  logic       sck_q     = 1'b0;
  wire  [7:0] rdata_o;
  wire  [7:0] sel_n;
  wire  [7:0] m_rx;
  wire        sck_o, cken, so, slave_out_driver_enable, mso, moen, irq_o, miso;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         n_rise = 0;
  int         first_r = 0;
  int         last_r = 0;

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  spims_core DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ss_n_i(ss_n_i), .sck_i(sck_i),
    .sck_o(sck_o), .clock_driver_enable_o(cken), .slave_in_i(slave_in_i),
    .slave_out_o(so), .slave_out_driver_enable_o(slave_out_driver_enable), .master_serial_in_i(miso),
    .master_serial_out_o(mso), .master_out_en_o(moen), .select_out_pins_n_o(sel_n),
    .irq_o(irq_o)
  );

  spims_slave_model u_slave (
    .sck_i(sck_o), .mosi_i(mso), .ss_n_i(sel_n[0]), .tx_i(m_tx), .miso_o(miso), .rx_o(m_rx)
  );

  // Serial clock monitor: counts rising edges and where they fall
  always @(posedge sys_clk_i) begin
    cyc   <= cyc + 1;
    sck_q <= sck_o;
    if (sck_o && !sck_q) begin
      if (n_rise == 0) begin
        first_r = cyc;
      end
      last_r = cyc;
      n_rise = n_rise + 1;
    end
  end

  task automatic summarize;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Polling arms the flag clear; a bound stops a hung transfer
  task automatic wait_done;
    for (int i = 0; i < 3000; i++) begin
      rd(`SPIMS_ADDR_FLAGS, v);
      if (v[7] === 1'b1) begin
        return;
      end
    end
    error_cnt++;
    summarize;
  endtask

  // One master character at rate code c; wc adds a colliding write
  task automatic xfer(input logic [2:0] c, input logic [7:0] tx, input logic [7:0] mrx, input logic wc);
    m_tx = mrx;
    wr(`SPIMS_ADDR_CTRL, {c[0], 1'b1, c[2], 1'b1, 2'b00, c[1:0]});
    #1 n_rise = 0;
    wr(`SPIMS_ADDR_DATA, tx);
    repeat (2) @(posedge sys_clk_i);
    #1 chk(sel_n, 8'hfe);
    chk({cken, moen}, 2'b11);
    if (wc) begin
      wr(`SPIMS_ADDR_DATA, ~tx);
    end
    wait_done;
    chk(v, {1'b1, wc, 6'b000001});
    chk(sel_n, 8'hff);
    chk(8'(n_rise), 8'h08);
    chk(16'(last_r - first_r), 16'(7 * (4 << c)));
    chk(irq_o, c[0]);
    rchk(`SPIMS_ADDR_DATA, mrx);
    chk(m_rx, tx);
    rchk(`SPIMS_ADDR_FLAGS, 8'h01);
    chk(irq_o, 1'b0);
  endtask

  // Slave character at phase ph; clock pulses with select high must be ignored
  task automatic sl(input logic ph, input logic [7:0] tx);
    wr(`SPIMS_ADDR_CTRL, {5'b01000, ph, 2'b00});
    wr(`SPIMS_ADDR_DATA, tx);
    repeat (6) begin
      repeat (8) @(posedge sys_clk_i);
      sck_i <= ~sck_i;
    end
    @(posedge sys_clk_i);
    ss_n_i <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (8) @(posedge sys_clk_i);
      slave_in_i <= SI[i];
      sck_i      <= ph;
      repeat (8) @(posedge sys_clk_i);
      v[i] = so;
      sck_i <= !ph;
      repeat (8) @(posedge sys_clk_i);
      sck_i <= 1'b0;
    end
    repeat (8) @(posedge sys_clk_i);
    chk(slave_out_driver_enable, 1'b1);
    ss_n_i <= 1'b1;
    chk(v, tx);
    rchk(`SPIMS_ADDR_FLAGS, 8'h81);
    rchk(`SPIMS_ADDR_DATA, SI);
    repeat (4) @(posedge sys_clk_i);
    #1 chk(slave_out_driver_enable, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rchk(`SPIMS_ADDR_CTRL, 8'h04);
    rchk(`SPIMS_ADDR_FLAGS, 8'h00);
    rchk(`SPIMS_ADDR_MASK, 8'hff);
    rchk(8'he0, 8'h00);
    chk({sel_n, irq_o}, 9'h1fe);
    wr(`SPIMS_ADDR_MASK, 8'hfe);
    wr(`SPIMS_ADDR_FLAGS, 8'h01);
    rchk(`SPIMS_ADDR_MASK, 8'hfe);
    for (int c = 0; c < 8; c++) begin
      xfer(c[2:0], 8'h96 ^ 8'(c), 8'h3c + 8'(c), c == 2);
    end
    wr(`SPIMS_ADDR_CTRL, 8'h58);
    repeat (2) @(posedge sys_clk_i);
    #1 chk(sck_o, 1'b1);
    // Another master pulls select low while this core is master
    wr(`SPIMS_ADDR_CTRL, 8'hd0);
    @(posedge sys_clk_i);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1 chk({cken, moen, irq_o}, 3'b001);
    rchk(`SPIMS_ADDR_CTRL, 8'h80);
    rchk(`SPIMS_ADDR_FLAGS, 8'h11);
    @(posedge sys_clk_i);
    ss_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    wr(`SPIMS_ADDR_CTRL, 8'h40);
    rchk(`SPIMS_ADDR_FLAGS, 8'h01);
    chk({irq_o, cken}, 2'b00);
    sl(1'b0, 8'ha5);
    sl(1'b1, 8'h5a);
    summarize;
  end
endmodule // spi_master_slave_port_tb_top

// >>> tb/spims_slave_model.sv
// Behavioural mode-0 slave that sits on the far side of the master port.
// Assumes it is selected by one active-low select output of the core.
module spims_slave_model (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       ss_n_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic      [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] out_q;
  logic [7:0] in_q;
  int         n;
  initial begin
    miso_o = 1'b0;
    rx_o   = 8'h00;
    out_q  = 8'h00;
    in_q   = 8'h00;
    n      = 0;
  end
  // Select low loads the reply and shows its top bit first
  always @(negedge ss_n_i) begin
    out_q  = tx_i;
    miso_o = tx_i[7];
    n      = 0;
  end
  // Leading edge samples, eight of them make one character
  always @(posedge sck_i) begin
    if (!ss_n_i) begin
      in_q = {in_q[6:0], mosi_i};
      n    = n + 1;
      if (n == 8) begin
        rx_o = in_q;
      end
    end
  end
  always @(negedge sck_i) begin
    if (!ss_n_i && n < 8) begin
      out_q  = out_q << 1;
      miso_o = out_q[7];
    end
  end
  // Released line flips so a stale bit never passes for data
  always @(posedge ss_n_i) begin
    miso_o = ~miso_o;
  end
endmodule // spims_slave_model
